// ===== hdl/interrupt_priority_vector_unit.sv
// interrupt priority resolution, vector selection and the priority/misc control register
// assumes peripheral requests already qualified by their own local enables except sci,
// and mode pins stable around the release of reset
//
// Our own choice: the address-and-strobe port.
`include "irq_vec_defs.svh"
//
// control register layout, msb first:
//   7 bootstrap rom read, live only while the special mode bit is set
//   6 special mode bit, caught from the inverted mode-b pin after reset
//   5 mode-a bit, caught from the true mode-a pin after reset
//   4 read visibility control, meaning depends on the mode-a bit
//   3..0 priority select code, reset value 0110 (external pin first)
//
// values captured on the first clock edge after reset is released:
//   mode-b mode-a   boot special_mode_bit mda vis
//     1      0       0    0    0   0   single chip
//     1      1       0    0    1   0   expanded
//     0      0       1    1    0   0   bootstrap
//     0      1       0    1    1   1   special test
// the capture sits one edge late on purpose: the reset branch of the
// flip-flops may only load constants, so the pins are read synchronously.
// software must not touch the register before the second edge.
//
// request vector, index equals fixed maskable rank, 0 is served first:
//   0 external pin (active low), 1..13 peripheral requests, 14 serial system
// peripheral requests arrive already qualified by their local enables;
// the serial system is qualified here because its five flags share enables.
//
// arbitration per clock:
//   non-maskable chain first, in fixed order, then the promoted source if it
//   is pending and unmasked, then the lowest pending rank index.
// promotion changes the order only: the promoted source keeps its vector and
// stays behind the global mask, so a promoted but masked source is not served.
//
// every output is registered, so the vector follows its inputs by one clock.
// a write to the select code while the global mask is clear is dropped
// silently; there is no error flag because software has no way to read one
// in time, and the rule is that the mask is set before the code changes.
//
// the clock output toggles on each eclk enable pulse while enabled and is
// held low otherwise, so the pin never shows a stale high level.
//
module interrupt_priority_vector_unit #(
  parameter int ADDR_W = 16
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        mode_a_select_pin,
  input  wire logic                        mode_b_select_pin,
  input  wire logic [ADDR_W-1:0]           reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        ccr_i_mask,
  input  wire logic                        ccr_x_mask,
  input  wire logic                        por_request,
  input  wire logic                        clock_monitor_fail,
  input  wire logic                        clock_monitor_enable,
  input  wire logic                        watchdog_fail,
  input  wire logic                        watchdog_disable,
  input  wire logic                        nonmaskable_request_pin_n,
  input  wire logic                        illegal_opcode,
  input  wire logic                        software_interrupt,
  input  wire logic                        ext_request_pin_n,
  input  wire logic [13:1]                 periph_request,
  input  irq_vec_pkg::sci_flags_t          sci_flags,
  input  irq_vec_pkg::sci_enables_t        sci_enables,
  input  wire logic                        sci_status_rd,
  input  wire logic                        sci_data_rd,
  input  wire logic                        internal_read,
  input  wire logic                        eclk_en,
  output irq_vec_pkg::vector_t             vector,
  output logic                             rx_full_clear,
  output logic                             read_visible,
  output logic                             eclk_out,
  output logic                             eclk_out_en
);
  initial begin
    if (ADDR_W < 16) $error("register address must be at least 16 bits");
  end

  // reset-capture state: rst_seen_q goes high on the first edge after release
  logic       rst_seen_q, rst_seen_d;
  logic       boot_q, boot_d;
  logic       special_mode_bit_q, special_mode_bit_d;
  logic       mda_q, mda_d;
  logic       vis_q, vis_d;
  logic [3:0] psel_q, psel_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rx_armed_q, rx_armed_d;
  logic       rx_clr_q, rx_clr_d;
  irq_vec_pkg::vector_t vec_q, vec_d;
  logic       rdvis_q, rdvis_d;
  logic       eclk_q, eclk_d;
  logic       eclk_oe_q, eclk_oe_d;

  logic [7:0] prio_reg;
  logic       hit;
  logic [14:0] req;
  logic [14:0] grant_mask;
  logic        sci_req;
  logic [3:0]  promoted;

  assign hit = (reg_addr == ADDR_W'(`PRIO_REG_ADDR));
  assign prio_reg = {boot_q & special_mode_bit_q, special_mode_bit_q, mda_q, vis_q, psel_q};

  // serial system request, receive full and overrun share one enable
  assign sci_req = (sci_enables.rx_irq_enable & (sci_flags.rx_full | sci_flags.overrun))
                 | (sci_enables.tx_empty_irq_enable & sci_flags.tx_empty)
                 | (sci_enables.tx_done_irq_enable & sci_flags.tx_done)
                 | (sci_enables.idle_irq_enable & sci_flags.idle);

  assign req = {sci_req, periph_request, ~ext_request_pin_n};

  // maps select code to the rank index of the source it promotes
  always_comb begin
    case (psel_q)
      `PSEL_TOF:    promoted = irq_vec_pkg::src_tof;
      `PSEL_PAOV:   promoted = irq_vec_pkg::src_paov;
      `PSEL_PAEDGE: promoted = irq_vec_pkg::src_paedge;
      `PSEL_SPI:    promoted = irq_vec_pkg::src_spi;
      `PSEL_SCI:    promoted = irq_vec_pkg::src_sci;
      `PSEL_RSVD:   promoted = irq_vec_pkg::src_ext;
      `PSEL_EXT:    promoted = irq_vec_pkg::src_ext;
      `PSEL_RTI:    promoted = irq_vec_pkg::src_rti;
      default: begin
        if (psel_q >= `PSEL_OC1 && psel_q < `PSEL_IC4OC5)
          promoted = 4'(psel_q - `PSEL_OC1) + irq_vec_pkg::src_oc1;
        else if (psel_q == `PSEL_IC4OC5)
          promoted = irq_vec_pkg::src_ic4oc5;
        else
          promoted = 4'(psel_q - `PSEL_IC1) + irq_vec_pkg::src_ic1;
      end
    endcase
  end

  // fixed vector for a maskable rank index; promotion never alters it
  function automatic logic [15:0] mvec(input logic [3:0] idx);
    logic [15:0] v;
    v = `VEC_SCI;
    case (idx)
      irq_vec_pkg::src_ext:    v = `VEC_EXT;
      irq_vec_pkg::src_rti:    v = `VEC_RTI;
      irq_vec_pkg::src_ic1,
      irq_vec_pkg::src_ic2,
      irq_vec_pkg::src_ic3:    v = 16'(`VEC_RTI - {idx - 4'(irq_vec_pkg::src_ic1) + 4'h1, 1'b0});
      irq_vec_pkg::src_oc1,
      irq_vec_pkg::src_oc2,
      irq_vec_pkg::src_oc3,
      irq_vec_pkg::src_oc4:    v = 16'(`VEC_OC4 + {4'(irq_vec_pkg::src_oc4) - idx, 1'b0});
      irq_vec_pkg::src_ic4oc5: v = `VEC_IC4OC5;
      irq_vec_pkg::src_tof:    v = `VEC_TOF;
      irq_vec_pkg::src_paov:   v = `VEC_PAOV;
      irq_vec_pkg::src_paedge: v = `VEC_PAEDGE;
      irq_vec_pkg::src_spi:    v = `VEC_SPI;
      default:                 v = `VEC_SCI;
    endcase
    return v;
  endfunction

  // register and mode state
  always_comb begin
    rst_seen_d = 1'b1;
    boot_d     = boot_q;
    special_mode_bit_d     = special_mode_bit_q;
    mda_d      = mda_q;
    vis_d      = vis_q;
    psel_d     = psel_q;
    rdata_d    = 8'h00;
    if (!rst_seen_q) begin
      // mode pins caught on the first edge after release, not under async reset
      special_mode_bit_d = ~mode_b_select_pin;
      mda_d  = mode_a_select_pin;
      boot_d = ~mode_b_select_pin & ~mode_a_select_pin;
      vis_d  = ~mode_b_select_pin & mode_a_select_pin;
    end else if (reg_wr && hit) begin
      boot_d = special_mode_bit_q & reg_wdata[`PRIO_BOOT_BIT];
      if (special_mode_bit_q) begin
        // only special modes may change operating mode bits
        special_mode_bit_d = reg_wdata[`PRIO_SPECIAL_MODE_BIT_BIT];
        mda_d  = reg_wdata[`PRIO_MDA_BIT];
      end
      vis_d = reg_wdata[`PRIO_VIS_BIT];
      if (ccr_i_mask) psel_d = reg_wdata[3:0];
    end
    if (reg_rd && hit) rdata_d = prio_reg;
  end

  // arbitration and vector choice
  always_comb begin
    logic found;
    found      = 1'b0;
    vec_d      = '0;
    grant_mask = req & {15{~ccr_i_mask}};
    // non-maskable chain ahead of every maskable source
    if (por_request) begin
      vec_d = '{valid: 1'b1, maskable: 1'b0, addr: `VEC_RESET};
    end else if (clock_monitor_fail && clock_monitor_enable) begin
      vec_d = '{valid: 1'b1, maskable: 1'b0, addr: `VEC_CLKMON};
    end else if (watchdog_fail && !watchdog_disable) begin
      vec_d = '{valid: 1'b1, maskable: 1'b0, addr: `VEC_WDOG};
    end else if (!nonmaskable_request_pin_n && !ccr_x_mask) begin
      vec_d = '{valid: 1'b1, maskable: 1'b0, addr: `VEC_NMI};
    end else if (illegal_opcode) begin
      vec_d = '{valid: 1'b1, maskable: 1'b0, addr: `VEC_ILLOP};
    end else if (software_interrupt) begin
      vec_d = '{valid: 1'b1, maskable: 1'b0, addr: `VEC_SWI};
    end else if (grant_mask[promoted]) begin
      vec_d = '{valid: 1'b1, maskable: 1'b1, addr: mvec(promoted)};
    end else begin
      for (int i = 14; i >= 0; i--) begin
        if (grant_mask[i]) begin
          found = 1'b1;
          vec_d = '{valid: 1'b1, maskable: 1'b1, addr: mvec(4'(i))};
        end
      end
      if (!found) vec_d = '0;
    end
  end

  // receive-full release: status read with flag set, then a data read
  always_comb begin
    rx_armed_d = rx_armed_q;
    rx_clr_d   = 1'b0;
    if (sci_status_rd && sci_flags.rx_full) rx_armed_d = 1'b1;
    else if (sci_data_rd && rx_armed_q) begin
      rx_armed_d = 1'b0;
      rx_clr_d   = 1'b1;
    end
  end

  // pins: expanded modes show internal reads, the others gate the clock out
  always_comb begin
    rdvis_d   = mda_q & vis_q & internal_read;
    eclk_oe_d = ~mda_q & vis_q;
    eclk_d    = eclk_oe_d & (eclk_en ? ~eclk_q : eclk_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_seen_q <= 1'b0;
      boot_q     <= 1'b0;
      special_mode_bit_q     <= 1'b0;
      mda_q      <= 1'b0;
      vis_q      <= 1'b0;
      psel_q     <= `PRIO_SEL_RESET;
      rdata_q    <= 8'h00;
      vec_q      <= '0;
      rx_armed_q <= 1'b0;
      rx_clr_q   <= 1'b0;
      rdvis_q    <= 1'b0;
      eclk_q     <= 1'b0;
      eclk_oe_q  <= 1'b0;
    end else begin
      rst_seen_q <= rst_seen_d;
      boot_q     <= boot_d;
      special_mode_bit_q     <= special_mode_bit_d;
      mda_q      <= mda_d;
      vis_q      <= vis_d;
      psel_q     <= psel_d;
      rdata_q    <= rdata_d;
      vec_q      <= vec_d;
      rx_armed_q <= rx_armed_d;
      rx_clr_q   <= rx_clr_d;
      rdvis_q    <= rdvis_d;
      eclk_q     <= eclk_d;
      eclk_oe_q  <= eclk_oe_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign vector        = vec_q;
  assign rx_full_clear = rx_clr_q;
  assign read_visible  = rdvis_q;
  assign eclk_out      = eclk_q;
  assign eclk_out_en   = eclk_oe_q;
endmodule

// ===== pkg/irq_vec_defs.svh
// register offset, field positions, reset values and vector addresses of the priority unit
// assumes a 16-bit register address space and 16-bit vector addresses
`ifndef IRQ_VEC_DEFS_SVH
`define IRQ_VEC_DEFS_SVH
`define PRIO_REG_ADDR      16'h103c
`define PRIO_BOOT_BIT      7
`define PRIO_SPECIAL_MODE_BIT_BIT      6
`define PRIO_MDA_BIT       5
`define PRIO_VIS_BIT       4
`define PRIO_SEL_RESET     4'h6
`define PSEL_TOF           4'h0
`define PSEL_PAOV          4'h1
`define PSEL_PAEDGE        4'h2
`define PSEL_SPI           4'h3
`define PSEL_SCI           4'h4
`define PSEL_RSVD          4'h5
`define PSEL_EXT           4'h6
`define PSEL_RTI           4'h7
`define PSEL_IC1           4'h8
`define PSEL_OC1           4'hb
`define PSEL_IC4OC5        4'hf
`define VEC_SCI            16'hffd6
`define VEC_SPI            16'hffd8
`define VEC_PAEDGE         16'hffda
`define VEC_PAOV           16'hffdc
`define VEC_TOF            16'hffde
`define VEC_IC4OC5         16'hffe0
`define VEC_OC4            16'hffe2
`define VEC_IC3            16'hffea
`define VEC_RTI            16'hfff0
`define VEC_EXT            16'hfff2
`define VEC_NMI            16'hfff4
`define VEC_SWI            16'hfff6
`define VEC_ILLOP          16'hfff8
`define VEC_WDOG           16'hfffa
`define VEC_CLKMON         16'hfffc
`define VEC_RESET          16'hfffe
`endif

// ===== pkg/irq_vec_pkg.sv
// types shared by the priority unit and its bench
// assumes nothing beyond the defs header
package irq_vec_pkg;
  // maskable sources, index order equals fixed arbitration order
  typedef enum logic [3:0] {
    src_ext    = 4'h0,
    src_rti    = 4'h1,
    src_ic1    = 4'h2,
    src_ic2    = 4'h3,
    src_ic3    = 4'h4,
    src_oc1    = 4'h5,
    src_oc2    = 4'h6,
    src_oc3    = 4'h7,
    src_oc4    = 4'h8,
    src_ic4oc5 = 4'h9,
    src_tof    = 4'ha,
    src_paov   = 4'hb,
    src_paedge = 4'hc,
    src_spi    = 4'hd,
    src_sci    = 4'he
  } mask_src_t;

  typedef struct packed {
    logic rx_full;
    logic overrun;
    logic tx_empty;
    logic tx_done;
    logic idle;
  } sci_flags_t;

  typedef struct packed {
    logic rx_irq_enable;
    logic tx_empty_irq_enable;
    logic tx_done_irq_enable;
    logic idle_irq_enable;
  } sci_enables_t;

  typedef struct packed {
    logic        valid;
    logic        maskable;
    logic [15:0] addr;
  } vector_t;
endpackage

// ===== sim/irq_vec_unit_sva.sv
// concurrent checks on the ports of the interrupt priority and vector unit
// assumes one clock domain and the registered one-cycle output timing of the unit
module irq_vec_unit_sva #(
  parameter int ADDR_W = 16
) (
  input logic                     clk,
  input logic                     rst,
  input logic [ADDR_W-1:0]        reg_addr,
  input logic                     reg_rd,
  input logic [7:0]               reg_rdata,
  input logic                     ccr_i_mask,
  input logic                     ccr_x_mask,
  input logic                     por_request,
  input logic                     clock_monitor_fail,
  input logic                     watchdog_fail,
  input logic                     nonmaskable_request_pin_n,
  input logic                     illegal_opcode,
  input logic                     software_interrupt,
  input logic                     ext_request_pin_n,
  input logic [13:1]              periph_request,
  input irq_vec_pkg::sci_flags_t  sci_flags,
  input logic                     sci_status_rd,
  input logic                     sci_data_rd,
  input logic                     internal_read,
  input irq_vec_pkg::vector_t     vector,
  input logic                     rx_full_clear,
  input logic                     read_visible
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // fail inputs count as live whatever their enables, so this stays conservative
  wire sys_quiet = !por_request && !clock_monitor_fail && !watchdog_fail && !illegal_opcode
                   && !software_interrupt && nonmaskable_request_pin_n;
  sequence s_status_then_data;
    sci_status_rd && sci_flags.rx_full ##1 sci_data_rd;
  endsequence
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property (reg_rd && reg_addr != 16'h103c |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  AST_MASKED: assert property (ccr_i_mask && sys_quiet |=> !vector.valid)
    else $error("maskable request served while masked");
  AST_POR_FIRST: assert property (por_request |=> vector.addr == 16'hfffe)
    else $error("reset vector not first");
  AST_EXT_VEC: assert property (!ccr_i_mask && !ext_request_pin_n && sys_quiet
      && periph_request == '0 && sci_flags == '0 |=> vector.maskable && vector.addr == 16'hfff2)
    else $error("external pin vector wrong");
  AST_NMI_VEC: assert property (!nonmaskable_request_pin_n && !ccr_x_mask && !por_request
      && !clock_monitor_fail && !watchdog_fail |=> !vector.maskable && vector.addr == 16'hfff4)
    else $error("nonmaskable pin vector wrong");
  AST_RX_CLEAR: assert property (s_status_then_data |=> rx_full_clear)
    else $error("receive flag clear missing");
  AST_RX_CAUSE: assert property (rx_full_clear |-> $past(sci_data_rd))
    else $error("receive flag clear without data read");
  AST_VIS_CAUSE: assert property (read_visible |-> $past(internal_read))
    else $error("read visibility without internal read");
endmodule
bind interrupt_priority_vector_unit irq_vec_unit_sva #(.ADDR_W(ADDR_W)) chk_u (.*);

// ===== sim/irq_source_model.sv
// far-side model: serial receive flag source and core clock-enable pulses
// assumes the unit's receive clear pulse lasts one clock
module irq_source_model (
  input  logic clk,
  input  logic rst,
  input  logic rx_set,
  input  logic rx_full_clear,
  output logic rx_full,
  output logic eclk_en
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_full <= 1'b0;
      eclk_en <= 1'b0;
    end else begin
      eclk_en <= !eclk_en;
      // the flag holds its request until the status-then-data pair is seen
      if (rx_full_clear) begin
        rx_full <= 1'b0;
      end else if (rx_set) begin
        rx_full <= 1'b1;
      end
    end
  end
endmodule

// ===== sim/tb.sv
// self-checking bench for the interrupt priority and vector unit
// assumes special test mode pins held steady and the source model beside the unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, mode_a_select_pin, mode_b_select_pin, reg_wr, reg_rd, ccr_i_mask, ccr_x_mask;
  logic por_request, clock_monitor_fail, clock_monitor_enable, watchdog_fail, watchdog_disable;
  logic nonmaskable_request_pin_n, illegal_opcode, software_interrupt, ext_request_pin_n;
  logic sci_status_rd, sci_data_rd, internal_read, eclk_en, rx_full_clear, read_visible;
  logic eclk_out, eclk_out_en, rx_set, rx_full;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [13:1] periph_request;
  logic [3:0] sci_rest;
  logic [5:0] nm;
  logic e0;
  logic [15:0] nmv [6] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff4, 16'hfff8, 16'hfff6};
  irq_vec_pkg::sci_flags_t sci_flags;
  irq_vec_pkg::sci_enables_t sci_enables;
  irq_vec_pkg::vector_t vector;
  int failures = 0;
  int samples_checked = 0;
  assign sci_flags = {rx_full, sci_rest};
  interrupt_priority_vector_unit #(.ADDR_W(16)) dut_u (.*);
  irq_source_model src_u (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    reg_addr <= 16'h103c;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check({9'h0, reg_rdata}, {9'h0, e});
  endtask
  // three edges cover the source model's own register stage as well
  task automatic vchk(input logic [16:0] e);
    repeat (3) @(posedge clk);
    #1;
    check({vector.valid, vector.addr}, e);
  endtask
  function automatic logic [15:0] vaddr(input int k);
    return 16'hfff2 - 16'(2 * k);
  endfunction
  function automatic int prom(input int c);
    case (c)
      0, 1, 2, 3, 4: return c + 10;
      5, 6: return 0;
      default: return c - 6;
    endcase
  endfunction
  task automatic wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {reg_wr, reg_rd, ccr_i_mask, ccr_x_mask, por_request, clock_monitor_fail, watchdog_fail,
     watchdog_disable, illegal_opcode, software_interrupt, sci_status_rd, sci_data_rd,
     internal_read, rx_set, mode_b_select_pin, reg_addr, reg_wdata, periph_request} = '0;
    {rst, mode_a_select_pin, clock_monitor_enable, nonmaskable_request_pin_n} = '1;
    ext_request_pin_n = 1'b1;
    sci_rest = 4'h0;
    sci_enables = '1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(16'h103c, 8'h76);
    rdchk(16'h103d, 8'h00);
    wr(8'h72);
    rdchk(16'h103c, 8'h76);
    @(posedge clk);
    ext_request_pin_n <= 1'b0;
    vchk({1'b1, 16'hfff2});
    for (int c = 0; c < 16; c++) begin
      @(posedge clk);
      ccr_i_mask <= 1'b1;
      wr({4'h7, 4'(c)});
      @(posedge clk);
      ccr_i_mask <= 1'b0;
      periph_request <= '1;
      sci_rest <= 4'h4;
      vchk({1'b1, vaddr(prom(c))});
    end
    // promoted source is capture4/compare5, so it wins once it is pending
    for (int k = 14; k > 0; k--) begin
      @(posedge clk);
      ext_request_pin_n <= 1'b1;
      periph_request <= 13'h1fff << (k - 1);
      vchk({1'b1, vaddr(k > 9 ? k : 9)});
    end
    @(posedge clk);
    ccr_i_mask <= 1'b1;
    vchk(17'h0);
    for (int i = 0; i < 6; i++) begin
      nm = 6'h3f >> i;
      @(posedge clk);
      {por_request, clock_monitor_fail, watchdog_fail} <= nm[5:3];
      {illegal_opcode, software_interrupt} <= nm[1:0];
      nonmaskable_request_pin_n <= !nm[2];
      vchk({1'b1, nmv[i]});
    end
    @(posedge clk);
    {clock_monitor_fail, watchdog_fail, software_interrupt} <= 3'b110;
    {ccr_x_mask, watchdog_disable, clock_monitor_enable} <= 3'b110;
    nonmaskable_request_pin_n <= 1'b0;
    vchk(17'h0);
    @(posedge clk);
    {clock_monitor_fail, watchdog_fail, ccr_i_mask, sci_rest, periph_request} <= '0;
    nonmaskable_request_pin_n <= 1'b1;
    rx_set <= 1'b1;
    @(posedge clk);
    rx_set <= 1'b0;
    vchk({1'b1, 16'hffd6});
    @(posedge clk);
    sci_status_rd <= 1'b1;
    @(posedge clk);
    {sci_status_rd, sci_data_rd} <= 2'b01;
    @(posedge clk);
    sci_data_rd <= 1'b0;
    vchk(17'h0);
    @(posedge clk);
    ccr_i_mask <= 1'b1;
    internal_read <= 1'b1;
    wr(8'h72);
    rdchk(16'h103c, 8'h72);
    check({15'h0, read_visible, eclk_out_en}, 17'h2);
    check({16'h0, eclk_out}, 17'h0);
    wr(8'h52);
    rdchk(16'h103c, 8'h52);
    check({15'h0, read_visible, eclk_out_en}, 17'h1);
    e0 = eclk_out;
    repeat (2) @(posedge clk);
    #1;
    check({16'h0, eclk_out}, {16'h0, ~e0});
    wr(8'hd2);
    rdchk(16'h103c, 8'hd2);
    wr(8'h12);
    wr(8'h92);
    rdchk(16'h103c, 8'h12);
    wr(8'h77);
    rdchk(16'h103c, 8'h17);
    wrap_up();
  end
  initial begin
    #(40 * 4000);
    failures++;
    wrap_up();
  end
endmodule
